/* File: verilog/adcis_top.sv */
/*
 converter initial control, sequencer priority and software start
 registers behind an APB slave, with the start scheduler.
 assumes the converter, its FIFOs and the active-sequencer register
 sit on pclk and report through the plain ports below.
*/
// Chosen here: the APB slave port.
//
// Function
// - macro test mode is on only while the test field holds the key.
// - the converter clock is divided by the 4-bit divider, zero passes it through.
// - the reference bit picks the supply rail at 0 and the external input at 1.
// - with the reset policy at 0 a non-empty FIFO is kept when a sequence starts.
// - with the policy at 1 the FIFO is cleared at start only on overflow or endpoint.
// - analog inputs connect only while their enable bit is 1, fields reset to zero.
// - a 1 in an initiate bit starts that sequencer only if it is active.
// - any one or any combination of the four sequencers may start in one write.
// - sequencers started together run one after another by priority.
// - one trigger-type bit per sequencer in bits 4 to 7, 0 edge and 1 level.
// - the initiate bits are write-only strobes at bits 0 to 3.
// - reserved upper bits are read-only and read as zero.
// - 2-bit priorities, zero highest, reset order 0 to 3, all distinct; equal values are accepted, ties go to the lower index.
`timescale 1ns/1ns
`default_nettype none
`include "adcis_params.svh"
module adcis_top
    import adcis_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [3:0]  seq_active,
    input  wire logic [3:0]  fifo_overflow,
    input  wire logic        last_seq_endpoint,
    output logic             seq_start_valid,
    input  wire logic        seq_start_ready,
    output logic [1:0]       seq_start_id,
    input  wire logic        seq_done,
    output logic [3:0]       fifo_clear,
    output logic [3:0]       seq_trigger_level,
    output adcis_ctrl_s      conv_ctrl,
    output logic [3:0]       converter_clock_divider,
    output logic             conv_clk_tick
);
    logic [15:0]  init_reg;
    logic [3:0]   trig_type;
    adcis_prio_t  prio;
    logic [3:0]   pending;
    logic [3:0]   next_pending;
    adcis_state_e state;
    adcis_state_e next_state;
    logic [1:0]   issue_id;

    logic         setup;
    logic         access_wr;
    logic         hit_init;
    logic         hit_start;
    logic         hit_prio;
    logic         hit_any;
    logic [31:0]  rd_mux;
    logic         wr_init;
    logic         wr_start;
    logic         wr_prio;
    logic [3:0]   strobe_set;
    logic [3:0]   issue_clr;
    logic         grant_valid;
    logic [1:0]   grant_id;
    logic         grant_take;
    logic         clear_due;
    logic [3:0]   key_field;
    logic         test_on;
    logic         pick_best;

    // bus decode
    assign setup     = psel && !penable;
    assign access_wr = psel && penable && pwrite && pready;
    assign hit_init  = (paddr == `ADCIS_OFS_INIT);
    assign hit_start = (paddr == `ADCIS_OFS_START);
    assign hit_prio  = (paddr == `ADCIS_OFS_PRIORITY);
    assign hit_any   = hit_init || hit_start || hit_prio;
    assign wr_init   = access_wr && hit_init;
    assign wr_start  = access_wr && hit_start;
    assign wr_prio   = access_wr && hit_prio;

    // zero wait states; read data is caught in the setup cycle
    assign pready = 1'b1;

    assign rd_mux = hit_init  ? ({16'h0000, init_reg} & `ADCIS_INIT_MASK) :
                    hit_start ? ({24'h000000, trig_type, 4'h0} & `ADCIS_START_MASK) :
                    hit_prio  ? ({16'h0000, 2'b00, prio[3], 2'b00, prio[2],
                                  2'b00, prio[1], 2'b00, prio[0]} & `ADCIS_PRIO_MASK) :
                    32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata  <= pwrite ? 32'h00000000 : rd_mux;
            pslverr <= !hit_any;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_reg <= `ADCIS_INIT_RESET;
        end else if (wr_init) begin
            init_reg <= pwdata[15:0] & 16'(`ADCIS_INIT_MASK);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_type <= `ADCIS_TRIG_RESET;
        end else if (wr_start) begin
            trig_type <= pwdata[`ADCIS_TRIG_MSB:`ADCIS_TRIG_LSB];
        end
    end

    // priority fields, reset order 0 to 3
    for (genvar s = 0; s < 4; s++) begin : g_prio
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                prio[s] <= 2'(`ADCIS_PRIO_RESET >> (s * `ADCIS_PRIO_STRIDE));
            end else if (wr_prio) begin
                prio[s] <= pwdata[s * `ADCIS_PRIO_STRIDE +: 2];
            end
        end
    end

    // test mode only on exact key
    assign key_field = init_reg[`ADCIS_TEST_KEY_MSB:`ADCIS_TEST_KEY_LSB];
    assign test_on   = (key_field == `ADCIS_TEST_KEY);
    // converter control fields from the init register
    // one assignment, a packed struct is a single variable
    assign conv_ctrl = {test_on,
                        init_reg[`ADCIS_REF_BIT],
                        init_reg[`ADCIS_POLICY_BIT],
                        init_reg[`ADCIS_CONVERTER_CLOCK_GATE_BIT],
                        init_reg[`ADCIS_AIN_BIT]};
    assign converter_clock_divider        = init_reg[`ADCIS_DIV_MSB:`ADCIS_DIV_LSB];
    assign seq_trigger_level              = trig_type;

    // divider changes with the gate on may give one odd tick period
    adcis_converter_clock_divider u_converter_clock_divider (
        .pclk    (pclk),
        .presetn (presetn),
        .gate    (conv_ctrl.converter_clock_gate),
        .div     (converter_clock_divider),
        .tick    (conv_clk_tick)
    );

    assign strobe_set = wr_start ? (pwdata[`ADCIS_STROBE_MSB:`ADCIS_STROBE_LSB] & seq_active)
                                 : 4'h0;

    assign grant_take = (state == ST_ISSUE) && seq_start_ready;
    assign issue_clr  = grant_take ? (4'h1 << issue_id) : 4'h0;

    // set wins over the clear of the same cycle
    assign next_pending = (pending & ~issue_clr) | strobe_set;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= 4'h0;
        end else begin
            pending <= next_pending;
        end
    end

    adcis_arbiter u_arbiter (
        .pending     (pending),
        .prio        (prio),
        .grant_valid (grant_valid),
        .grant_id    (grant_id)
    );

    // pick checked apart from the arbiter
    assign pick_best = pending[grant_id] &&
                       (!pending[0] || prio[grant_id] <= prio[0]) &&
                       (!pending[1] || prio[grant_id] <= prio[1]) &&
                       (!pending[2] || prio[grant_id] <= prio[2]) &&
                       (!pending[3] || prio[grant_id] <= prio[3]);

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (grant_valid) begin
                    next_state = ST_ISSUE;
                end
            end
            ST_ISSUE: begin
                if (seq_start_ready) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (seq_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // policy 1 clears on overflow or endpoint
    assign clear_due = conv_ctrl.fifo_reset_policy &&
                       (fifo_overflow[grant_id] || last_seq_endpoint);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state      <= ST_IDLE;
            issue_id   <= 2'h0;
            fifo_clear <= 4'h0;
        end else begin
            state      <= next_state;
            fifo_clear <= 4'h0;
            if (state == ST_IDLE && grant_valid) begin
                issue_id   <= grant_id;
                fifo_clear <= clear_due ? (4'h1 << grant_id) : 4'h0;
            end
        end
    end

    assign seq_start_valid = (state == ST_ISSUE);
    assign seq_start_id    = issue_id;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_test_key: assert property (wr_init |=> conv_ctrl.macro_test_mode ==
        ($past(pwdata[`ADCIS_TEST_KEY_MSB:`ADCIS_TEST_KEY_LSB]) == `ADCIS_TEST_KEY))
        else $error("test mode not tied to key");

    chk_ref_write: assert property (
        wr_init |=> conv_ctrl.reference_external == $past(pwdata[`ADCIS_REF_BIT]))
        else $error("reference select did not follow write");

    chk_keep_fifo: assert property (
        (state == ST_IDLE && grant_valid && !conv_ctrl.fifo_reset_policy)
        |=> fifo_clear == 4'h0)
        else $error("fifo cleared with keep policy");

    chk_clear_cause: assert property (
        (fifo_clear != 4'h0) |-> $past(conv_ctrl.fifo_reset_policy) &&
        ($past(last_seq_endpoint) || ($past(fifo_overflow) & fifo_clear) != 4'h0))
        else $error("fifo clear without cause");

    chk_ain_write: assert property (
        wr_init |=> conv_ctrl.analog_input_enable == $past(pwdata[`ADCIS_AIN_BIT]))
        else $error("analog enable did not follow write");

    chk_start_gated: assert property (
        (wr_start && !seq_active[0] && !pending[0]) |=> !pending[0])
        else $error("inactive sequencer started");

    chk_start_taken: assert property (
        (wr_start && (pwdata[3:0] & seq_active) == 4'hf) |=> pending == 4'hf)
        else $error("combined start lost");

    chk_priority_order: assert property ((state == ST_IDLE && grant_valid) |->
        pick_best ##1 (state == ST_ISSUE && issue_id == $past(grant_id)))
        else $error("start pick not the highest priority");

    chk_trig_write: assert property (
        wr_start |=> seq_trigger_level == $past(pwdata[7:4]))
        else $error("trigger type did not follow write");

    chk_strobe_read: assert property (
        (setup && !pwrite && hit_start) |=> prdata[3:0] == 4'h0)
        else $error("strobe bits read nonzero");

    chk_reserved_zero: assert property (
        (setup && !pwrite) |=> prdata[31:16] == 16'h0000)
        else $error("reserved bits read nonzero");

    chk_zero_no_effect: assert property (
        (wr_start && !pwdata[1] && !pending[1]) |=> !pending[1])
        else $error("zero strobe started sequencer");

    chk_issue_handshake: assert property (
        (seq_start_valid && !seq_start_ready) |=> seq_start_valid && $stable(seq_start_id))
        else $error("start request dropped before ready");

    chk_div_write: assert property (
        wr_init |=> converter_clock_divider == $past(pwdata[`ADCIS_DIV_MSB:`ADCIS_DIV_LSB]))
        else $error("divider did not follow write");

    chk_policy_write: assert property (
        wr_init |=> conv_ctrl.fifo_reset_policy == $past(pwdata[`ADCIS_POLICY_BIT]))
        else $error("reset policy did not follow write");

    chk_gate_write: assert property (
        wr_init |=> conv_ctrl.converter_clock_gate == $past(pwdata[`ADCIS_CONVERTER_CLOCK_GATE_BIT]))
        else $error("clock gate did not follow write");

    chk_prio_write: assert property (wr_prio |=>
        prio == $past({pwdata[13:12], pwdata[9:8], pwdata[5:4], pwdata[1:0]}))
        else $error("priorities did not follow write");

    chk_unmapped_err: assert property (
        (setup && !hit_any) |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");

    chk_clear_onehot: assert property (
        (fifo_clear != 4'h0) |-> $onehot(fifo_clear))
        else $error("fifo clear for more than one sequencer");

    chk_run_hold: assert property (
        (state == ST_RUN && !seq_done) |=> (state == ST_RUN) && !seq_start_valid)
        else $error("new start while a sequence runs");

    chk_taken_clears: assert property (
        (grant_take && !strobe_set[issue_id]) |=> !pending[issue_id])
        else $error("started sequencer still pending");

    cov_multi_start: cover property (wr_start && pwdata[3:0] == 4'hf && seq_active == 4'hf);
    cov_fifo_clear: cover property (fifo_clear != 4'h0);
    cov_test_mode: cover property (conv_ctrl.macro_test_mode);
    cov_back_to_back: cover property (seq_done ##2 seq_start_valid);

endmodule : adcis_top
`default_nettype wire

/* File: verilog/adcis_params.svh */
/*
 register offsets, field positions, reset values and keys of the
 converter initial-control and software-start block.
 assumes inclusion by bare name from the design files of this block.
*/
`ifndef ADCIS_PARAMS_SVH
`define ADCIS_PARAMS_SVH

`define ADCIS_OFS_PRIORITY     12'h024
`define ADCIS_OFS_INIT         12'h02c
`define ADCIS_OFS_START        12'h030

`define ADCIS_TEST_KEY_MSB     15
`define ADCIS_TEST_KEY_LSB     12
`define ADCIS_DIV_MSB          7
`define ADCIS_DIV_LSB          4
`define ADCIS_REF_BIT          3
`define ADCIS_POLICY_BIT       2
`define ADCIS_CONVERTER_CLOCK_GATE_BIT        1
`define ADCIS_AIN_BIT          0
`define ADCIS_TRIG_MSB         7
`define ADCIS_TRIG_LSB         4
`define ADCIS_STROBE_MSB       3
`define ADCIS_STROBE_LSB       0
`define ADCIS_PRIO_STRIDE      4

`define ADCIS_TEST_KEY         4'hd
`define ADCIS_INIT_MASK        32'h0000f0ff
`define ADCIS_START_MASK       32'h000000f0
`define ADCIS_PRIO_MASK        32'h00003333
`define ADCIS_PRIO_RESET       32'h00003210
`define ADCIS_INIT_RESET       16'h0000
`define ADCIS_TRIG_RESET       4'h0

`endif

/* File: verilog/adcis_pkg.sv */
/*
 types shared by the converter initial-control and start block.
 assumes nothing beyond a SystemVerilog compiler.
*/
package adcis_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_RUN
    } adcis_state_e;

    typedef struct packed {
        logic macro_test_mode;
        logic reference_external;
        logic fifo_reset_policy;
        logic converter_clock_gate;
        logic analog_input_enable;
    } adcis_ctrl_s;

    typedef logic [3:0][1:0] adcis_prio_t;

endpackage : adcis_pkg

/* File: verilog/adcis_converter_clock_divider.sv */
/*
 converter clock divider: one-cycle tick every max(div,1) pclk cycles.
 assumes gate and div come from registers on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none
module adcis_converter_clock_divider
    import adcis_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       gate,
    input  wire logic [3:0] div,
    output var  logic       tick
);
    logic [3:0] cnt;
    logic [3:0] last;
    logic [3:0] next_cnt;

    // count to divider
    // zero and one both mean no division
    assign last     = (div == 4'h0) ? 4'h0 : div - 4'h1;
    assign next_cnt = (!gate || cnt >= last) ? 4'h0 : cnt + 4'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 4'h0;
            tick <= 1'b0;
        end else begin
            cnt  <= next_cnt;
            tick <= gate && (cnt == 4'h0);
        end
    end

    chk_div_bypass: assert property (@(posedge pclk) disable iff (!presetn)
        (gate && div == 4'h0)[*3] |-> tick)
        else $error("undivided clock missed a tick");

    chk_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        !gate |=> !tick)
        else $error("tick while clock gate is off");

endmodule : adcis_converter_clock_divider
`default_nettype wire

/* File: verilog/adcis_arbiter.sv */
/*
 priority pick among pending sequencer starts; lower value wins.
 assumes distinct priorities; ties fall to the lower index.
*/
`timescale 1ns/1ns
`default_nettype none
module adcis_arbiter
    import adcis_pkg::*;
(
    input  wire logic [3:0]  pending,
    input  wire adcis_prio_t prio,
    output logic             grant_valid,
    output logic [1:0]       grant_id
);
    logic [3:0] wins;

    for (genvar i = 0; i < 4; i++) begin : g_seq
        logic [3:0] beats;
        for (genvar j = 0; j < 4; j++) begin : g_other
            if (i == j) begin : g_self
                assign beats[j] = 1'b1;
            end else begin : g_cmp
                assign beats[j] = !pending[j] || (prio[i] < prio[j]) ||
                                  ((prio[i] == prio[j]) && (i < j));
            end
        end
        assign wins[i] = pending[i] && (&beats);
    end

    assign grant_valid = |pending;
    assign grant_id    = wins[0] ? 2'h0 : wins[1] ? 2'h1 : wins[2] ? 2'h2 : 2'h3;

endmodule : adcis_arbiter
`default_nettype wire

/* File: tb/tb_adc_init_and_sequence_start.sv */
/*
 self-checking bench for the converter initial-control and start block.
 assumes adcis_top with its params header, APB on a 25 MHz pclk.
*/
`timescale 1ns/1ns
`default_nettype none
`include "adcis_params.svh"
module tb_adc_init_and_sequence_start import adcis_pkg::*;;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  seq_active, fifo_overflow, fifo_clear, seq_trigger_level;
    logic [3:0]  converter_clock_divider;
    logic        last_seq_endpoint, seq_start_valid, seq_start_ready, seq_done;
    logic        conv_clk_tick;
    logic [1:0]  seq_start_id;
    adcis_ctrl_s conv_ctrl;
    int          err_count, comparisons, ticks;
    int          clr_cnt[4];
    logic [31:0] init_w;

    adcis_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .seq_active(seq_active),
        .fifo_overflow(fifo_overflow), .last_seq_endpoint(last_seq_endpoint),
        .seq_start_valid(seq_start_valid), .seq_start_ready(seq_start_ready),
        .seq_start_id(seq_start_id), .seq_done(seq_done), .fifo_clear(fifo_clear),
        .seq_trigger_level(seq_trigger_level), .conv_ctrl(conv_ctrl),
        .converter_clock_divider(converter_clock_divider),
        .conv_clk_tick(conv_clk_tick));

    initial pclk = 1'b0;
    always #20 pclk = ~pclk;

    // counted on the falling edge so registered pulses have settled
    always @(negedge pclk) begin
        if (conv_clk_tick === 1'b1) ticks++;
        for (int i = 0; i < 4; i++) if (fifo_clear[i] === 1'b1) clr_cnt[i]++;
    end

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task apb(input logic [11:0] a, input logic w, input logic [31:0] d,
             output logic [31:0] r, output logic e);
        @(posedge pclk);
        paddr <= a; pwrite <= w; pwdata <= d; psel <= 1'b1; penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b1, d, r, e);
    endtask : wr

    // gate off before any divider change
    task init_wr(input logic [31:0] d);
        wr(`ADCIS_OFS_INIT, init_w & 32'hfffffffd);
        wr(`ADCIS_OFS_INIT, d & 32'hfffffffd);
        wr(`ADCIS_OFS_INIT, d);
        init_w = d;
    endtask : init_wr

    task rd(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(a, 1'b0, 32'h0, r, e);
        chk("prdata", exp, r);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask : rd

    // converter side: accept one start, then finish after a random delay
    task serve(input int id);
        int n;
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (seq_start_valid !== 1'b1 && n < 20);
        chk("start valid", 32'h1, {31'h0, seq_start_valid});
        chk("start id", id, {30'h0, seq_start_id});
        @(posedge pclk) seq_start_ready <= 1'b1;
        @(posedge pclk) seq_start_ready <= 1'b0;
        repeat ($urandom_range(1, 4)) @(posedge pclk);
        seq_done <= 1'b1;
        @(posedge pclk) seq_done <= 1'b0;
    endtask : serve

    task end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test

    // about 1000 cycles of tests, so ten times that is a hang
    initial begin
        #400000;
        err_count++;
        end_of_test();
    end

    initial begin
        logic [31:0] v, r;
        logic        e, pol;
        logic [3:0]  stb, trig;
        int          p[4], q[$], base[4], n, t0, per;
        adcis_ctrl_s ec;
        {psel, penable, pwrite, seq_start_ready, seq_done, last_seq_endpoint} = '0;
        paddr = 12'h000; pwdata = 32'h0; seq_active = 4'h0; fifo_overflow = 4'h0;
        presetn = 1'b0;
        init_w = 32'h0;
        void'($urandom(22487));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rd(`ADCIS_OFS_INIT, 32'h0);
        rd(`ADCIS_OFS_PRIORITY, `ADCIS_PRIO_RESET);
        rd(`ADCIS_OFS_START, 32'h0);
        chk("ctrl reset", 32'h0, {27'h0, conv_ctrl});
        $display("test reset values done");
        for (int k = 0; k < 8; k++) begin
            v = $urandom;
            if (k == 0) v[15:12] = `ADCIS_TEST_KEY;
            init_wr(v);
            rd(`ADCIS_OFS_INIT, v & `ADCIS_INIT_MASK);
            ec = {v[15:12] == `ADCIS_TEST_KEY, v[3], v[2], v[1], v[0]};
            chk("conv_ctrl", {27'h0, ec}, {27'h0, conv_ctrl});
            chk("divider", {28'h0, v[7:4]}, {28'h0, converter_clock_divider});
        end
        apb(12'h100, 1'b0, 32'h0, r, e);
        chk("unmapped data", 32'h0, r);
        chk("unmapped err", 32'h1, {31'h0, e});
        wr(`ADCIS_OFS_PRIORITY, 32'hffffffff);
        rd(`ADCIS_OFS_PRIORITY, `ADCIS_PRIO_MASK);
        $display("test control fields done");
        foreach (p[i]) p[i] = (i == 0) ? 0 : (i == 1) ? 1 : (i == 2) ? 3 : 15;
        foreach (p[i]) begin
            init_wr(p[i] << 4);
            repeat (3) @(posedge pclk);
            t0 = ticks;
            repeat (20) @(posedge pclk);
            chk("ticks gated", 32'h0, ticks - t0);
            init_wr((p[i] << 4) | 2);
            repeat (3) @(posedge pclk);
            per = (p[i] == 0) ? 1 : p[i];
            t0 = ticks;
            repeat (10 * per) @(posedge pclk);
            chk("ticks", 32'd10, ticks - t0);
        end
        $display("test clock divider done");
        for (int k = 0; k < 8; k++) begin
            foreach (p[i]) p[i] = i;
            for (int i = 3; i > 0; i--) begin
                n = $urandom_range(0, i);
                t0 = p[i]; p[i] = p[n]; p[n] = t0;
            end
            wr(`ADCIS_OFS_PRIORITY, p[0] | p[1] << 4 | p[2] << 8 | p[3] << 12);
            pol = 1'($urandom);
            stb = (k == 0) ? 4'h0 : (k == 1) ? 4'hf : 4'($urandom);
            trig = 4'($urandom);
            @(posedge pclk);
            seq_active <= (k == 1) ? 4'hf : 4'($urandom);
            fifo_overflow <= 4'($urandom);
            last_seq_endpoint <= 1'($urandom);
            init_wr({29'h0, pol, 2'b01});
            foreach (base[i]) base[i] = clr_cnt[i];
            q = {};
            for (int pr = 0; pr < 4; pr++)
                foreach (p[i]) if (p[i] == pr && stb[i] && seq_active[i]) q.push_back(i);
            wr(`ADCIS_OFS_START, {24'h0, trig, stb});
            foreach (q[j]) serve(q[j]);
            n = 0;
            repeat (10) begin
                @(negedge pclk);
                if (seq_start_valid !== 1'b0) n++;
            end
            chk("no extra start", 32'h0, n);
            foreach (base[i]) begin
                t0 = (i inside {q} && pol && (fifo_overflow[i] || last_seq_endpoint)) ? 1 : 0;
                chk("fifo clear", t0, clr_cnt[i] - base[i]);
            end
            rd(`ADCIS_OFS_START, {24'h0, trig, 4'h0});
            chk("trigger type", {28'h0, trig}, {28'h0, seq_trigger_level});
        end
        $display("test software start done");
        end_of_test();
    end
endmodule : tb_adc_init_and_sequence_start
`default_nettype wire
